// [hw/core_exec_pkg.sv]
package core_exec_pkg;
  localparam int PC_W = 21;
  localparam int DA_W = 12;
  localparam int SP_W = 5;
  // four-phase instruction cycle, one quarter per clock
  typedef enum logic [3:0] {
    Q1 = 4'b0001, Q2 = 4'b0010, Q3 = 4'b0100, Q4 = 4'b1000
  } quarter_t;
  // opcode fields
  localparam logic [7:0] OPC_MUL_LIT = 8'h0d;
  localparam logic [6:0] OPC_MUL_REG = 7'h01;
  localparam logic [6:0] OPC_NEG_REG = 7'h36;
  localparam logic [15:0] OPC_POP = 16'h0006;
  localparam logic [15:0] OPC_PUSH = 16'h0005;
  localparam logic [15:0] OPC_SRESET = 16'h00ff;
  localparam logic [15:0] OPC_NOP = 16'h0000;
  localparam logic [3:0] OPC_NOP2 = 4'hf;
  localparam logic [4:0] OPC_REL_CALL = 5'h1b;
  // operand addressing
  localparam logic [7:0] ILO_LIMIT = 8'h5f;
  localparam logic [3:0] SFR_BANK = 4'hf;
  localparam logic [3:0] LOW_BANK = 4'h0;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  // status flag positions
  localparam int FL_C = 0;
  localparam int FL_DC = 1;
  localparam int FL_Z = 2;
  localparam int FL_OV = 3;
  localparam int FL_N = 4;
  localparam logic [7:0] NEG_OV_VAL = 8'h80;
  // reset values
  localparam logic [7:0] W_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [3:0] BANK_RST = 4'h0;
  localparam logic [7:0] PROD_RST = 8'h00;
  localparam logic [PC_W-1:0] PC_RST = 21'h000000;
  // register byte offsets
  localparam logic [7:0] R_CTRL = 8'h00;
  localparam logic [7:0] R_WREG = 8'h04;
  localparam logic [7:0] R_STATUS = 8'h08;
  localparam logic [7:0] R_BANK = 8'h0c;
  localparam logic [7:0] R_PROD = 8'h10;
  localparam logic [7:0] R_PC = 8'h14;
  localparam logic [7:0] R_HEAD = 8'h18;
  localparam logic [7:0] R_SP = 8'h1c;
  localparam logic [7:0] R_INDEX = 8'h20;
  localparam logic [7:0] R_MPTR = 8'h24;
  localparam logic [7:0] R_MDATA = 8'h28;
  localparam int CT_RUN = 0;
  localparam int CT_EXT = 1;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;
endpackage : core_exec_pkg

// [hw/core_exec.sv]
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ps
module core_exec import core_exec_pkg::*; #(
  parameter int STACK_DEPTH = 31,
  parameter int DMEM_DEPTH = 4096
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [15:0] instr_i,
  input wire bus_req_t bus_req_i,
  output logic [31:0] rd_data_o,
  output logic [PC_W-1:0] pc_o,
  output logic [15:0] prod_o,
  output logic sreset_o
);

  typedef struct packed {
    quarter_t q;
    logic run;
    logic ext_en;
    logic [7:0] w;
    logic [7:0] status;
    logic [3:0] bank_sel;
    logic [7:0] prod_hi;
    logic [7:0] prod_lo;
    logic [PC_W-1:0] pc;
    logic [15:0] ir;
    logic flush;
    logic [7:0] opnd;
    logic [DA_W-1:0] ea;
    logic [SP_W-1:0] sp;
    logic [DA_W-1:0] fsr;
    logic [DA_W-1:0] mptr;
    logic [31:0] rdata;
    logic sreset;
  } state_t;

  state_t s_r;
  state_t s_nxt;
  logic rst_b_m_r;
  logic rst_b_r;
  logic [7:0] dmem [DMEM_DEPTH];
  logic [PC_W-1:0] stk [STACK_DEPTH];
  logic mem_we;
  logic [7:0] mem_wd;
  logic [DA_W-1:0] mem_wa;
  logic stk_we;
  logic [SP_W-1:0] stk_wa;
  logic [PC_W-1:0] head;

  ////////////////////////////////////////////////////////////////////
  // reset release: assert at once, release after two edges
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_b_m_r <= 1'b0;
      rst_b_r <= 1'b0;
    end else begin
      rst_b_m_r <= 1'b1;
      rst_b_r <= rst_b_m_r;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // decode of the latched instruction word
  logic is_mlit, is_mreg, is_neg, is_pop, is_push, is_rel_call;
  logic is_srst, is_nop;
  assign is_mlit = s_r.ir[15:8] == OPC_MUL_LIT;
  assign is_mreg = s_r.ir[15:9] == OPC_MUL_REG;
  assign is_neg = s_r.ir[15:9] == OPC_NEG_REG;
  assign is_pop = s_r.ir == OPC_POP;
  assign is_push = s_r.ir == OPC_PUSH;
  assign is_rel_call = s_r.ir[15:11] == OPC_REL_CALL;
  assign is_srst = s_r.ir == OPC_SRESET;
  assign is_nop = s_r.ir == OPC_NOP || s_r.ir[15:12] == OPC_NOP2;

  // stack head is the entry just below the pointer; empty reads zero
  assign head = (s_r.sp == '0) ? PC_RST : stk[s_r.sp - 1'b1];

  // operand address from the bank bit, bank register and index pointer
  function automatic logic [DA_W-1:0] resolve(
    input logic [15:0] ir,
    input logic [3:0] bank_sel,
    input logic ext,
    input logic [DA_W-1:0] idx
  );
    logic [7:0] f;
    f = ir[7:0];
    if (ir[8]) begin
      resolve = {bank_sel, f};
    end else if (ext && f <= ILO_LIMIT) begin
      resolve = DA_W'(idx + {4'h0, f});
    end else if (f <= ILO_LIMIT) begin
      resolve = {LOW_BANK, f};
    end else begin
      resolve = {SFR_BANK, f};
    end
  endfunction : resolve

  ////////////////////////////////////////////////////////////////////
  // next-state logic: quarters, execution, then register bus
  always_comb begin
    logic [7:0] neg;
    logic [15:0] prod;
    neg = 8'(~s_r.opnd + 8'h01);
    prod = '0;
    s_nxt = s_r;
    s_nxt.sreset = 1'b0;
    mem_we = 1'b0;
    mem_wa = s_r.ea;
    mem_wd = neg;
    stk_we = 1'b0;
    stk_wa = s_r.sp;
    if (s_r.run) begin
      unique case (s_r.q)
        Q1: begin
          s_nxt.q = Q2;
          s_nxt.ir = instr_i;
          s_nxt.ea = resolve(instr_i, s_r.bank_sel, s_r.ext_en, s_r.fsr);
        end
        Q2: begin
          s_nxt.q = Q3;
          s_nxt.opnd = dmem[s_r.ea];
          // a full stack drops the push rather than wrap
          if (!s_r.flush && (is_push || is_rel_call) &&
              s_r.sp != SP_W'(STACK_DEPTH)) begin
            stk_we = 1'b1;
            s_nxt.sp = s_r.sp + 1'b1;
          end
          if (!s_r.flush && is_srst) begin
            // registers go back, memory keeps its contents
            s_nxt.w = W_RST;
            s_nxt.status = STATUS_RST;
            s_nxt.bank_sel = BANK_RST;
            s_nxt.prod_hi = PROD_RST;
            s_nxt.prod_lo = PROD_RST;
            s_nxt.pc = PC_RST;
            s_nxt.sp = '0;
            s_nxt.fsr = '0;
            s_nxt.flush = 1'b1;
            s_nxt.sreset = 1'b1;
          end
        end
        Q3: begin
          s_nxt.q = Q4;
          if (!s_r.flush && is_pop && s_r.sp != '0) begin
            s_nxt.sp = s_r.sp - 1'b1;
          end
        end
        Q4: begin
          s_nxt.q = Q1;
          if (s_r.flush) begin
            // idle cycle while the new target is fetched
            s_nxt.flush = 1'b0;
          end else begin
            s_nxt.pc = s_r.pc + PC_STEP;
            if (is_mlit) begin
              prod = 16'(s_r.w) * 16'(s_r.ir[7:0]);
              {s_nxt.prod_hi, s_nxt.prod_lo} = prod;
            end else if (is_mreg) begin
              prod = 16'(s_r.w) * 16'(s_r.opnd);
              {s_nxt.prod_hi, s_nxt.prod_lo} = prod;
            end else if (is_neg) begin
              mem_we = 1'b1;
              s_nxt.status[FL_N] = neg[7];
              s_nxt.status[FL_OV] = s_r.opnd == NEG_OV_VAL;
              s_nxt.status[FL_C] = s_r.opnd == 8'h00;
              s_nxt.status[FL_DC] = s_r.opnd[3:0] == 4'h0;
              s_nxt.status[FL_Z] = neg == 8'h00;
            end else if (is_rel_call) begin
              s_nxt.pc = s_r.pc + PC_STEP +
                {{9{s_r.ir[10]}}, s_r.ir[10:0], 1'b0};
              s_nxt.flush = 1'b1;
            end
          end
        end
      endcase
    end
    // bus read, answered in the next cycle
    s_nxt.rdata = '0;
    if (bus_req_i.rd) begin
      unique case (bus_req_i.addr)
        R_CTRL: s_nxt.rdata = 32'({s_r.ext_en, s_r.run});
        R_WREG: s_nxt.rdata = 32'(s_r.w);
        R_STATUS: s_nxt.rdata = 32'(s_r.status);
        R_BANK: s_nxt.rdata = 32'(s_r.bank_sel);
        R_PROD: s_nxt.rdata = 32'({s_r.prod_hi, s_r.prod_lo});
        R_PC: s_nxt.rdata = 32'(s_r.pc);
        R_HEAD: s_nxt.rdata = 32'(head);
        R_SP: s_nxt.rdata = 32'(s_r.sp);
        R_INDEX: s_nxt.rdata = 32'(s_r.fsr);
        R_MPTR: s_nxt.rdata = 32'(s_r.mptr);
        R_MDATA: s_nxt.rdata = 32'(dmem[s_r.mptr]);
        default: s_nxt.rdata = '0;
      endcase
    end
    // bus write wins over the core for the same register
    if (bus_req_i.wr) begin
      unique case (bus_req_i.addr)
        R_CTRL: begin
          s_nxt.run = bus_req_i.wdata[CT_RUN];
          s_nxt.ext_en = bus_req_i.wdata[CT_EXT];
          if (!bus_req_i.wdata[CT_RUN]) begin
            s_nxt.q = Q1;
            s_nxt.flush = 1'b0;
          end
        end
        R_WREG: s_nxt.w = bus_req_i.wdata[7:0];
        R_STATUS: s_nxt.status = bus_req_i.wdata[7:0];
        R_BANK: s_nxt.bank_sel = bus_req_i.wdata[3:0];
        R_PC: s_nxt.pc = bus_req_i.wdata[PC_W-1:0];
        R_INDEX: s_nxt.fsr = bus_req_i.wdata[DA_W-1:0];
        R_MPTR: s_nxt.mptr = bus_req_i.wdata[DA_W-1:0];
        R_MDATA: begin
          // one write port: a negate write-back takes it first
          if (!mem_we) begin
            mem_we = 1'b1;
            mem_wa = s_r.mptr;
            mem_wd = bus_req_i.wdata[7:0];
          end
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_i or negedge rst_b_r) begin
    if (!rst_b_r) begin
      s_r <= '{q: Q1, run: 1'b0, ext_en: 1'b0, w: W_RST,
               status: STATUS_RST, bank_sel: BANK_RST, prod_hi: PROD_RST,
               prod_lo: PROD_RST, pc: PC_RST, ir: OPC_NOP,
               flush: 1'b0, opnd: 8'h00, ea: '0, sp: '0,
               fsr: '0, mptr: '0, rdata: '0, sreset: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // data memory and return stack arrays, not reset
  always_ff @(posedge clk_i) begin
    if (mem_we) begin
      dmem[mem_wa] <= mem_wd;
    end
    if (stk_we) begin
      stk[stk_wa] <= s_r.pc + PC_STEP;
    end
  end

  assign rd_data_o = s_r.rdata;
  assign pc_o = s_r.pc;
  assign prod_o = {s_r.prod_hi, s_r.prod_lo};
  assign sreset_o = s_r.sreset;

  ////////////////////////////////////////////////////////////////////
  // checks
  logic ex4;
  logic quiet;
  assign ex4 = s_r.run && s_r.q == Q4 && !s_r.flush;
  assign quiet = !bus_req_i.wr;

  lit_product_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_r)
    ex4 && is_mlit |=> prod_o == 16'($past(s_r.w)) *
      16'($past(s_r.ir[7:0])))
    else $error("literal multiply product wrong");

  reg_product_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_r)
    ex4 && is_mreg |=> prod_o == 16'($past(s_r.w)) *
      16'($past(s_r.opnd)))
    else $error("register multiply product wrong");

  // only the register form has a file operand to hold against memory
  mul_flags_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_r)
    ex4 && (is_mlit || is_mreg) && quiet |=>
      $stable(s_r.status) && $stable(s_r.w) &&
      (!$past(is_mreg) || dmem[$past(s_r.ea)] == $past(s_r.opnd)))
    else $error("multiply disturbed flags or operands");

  bank_pick_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_r)
    s_r.run && s_r.q == Q1 && instr_i[8] |=>
      s_r.ea == {$past(s_r.bank_sel), $past(instr_i[7:0])})
    else $error("banked operand address wrong");

  indexed_mode_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_r)
    s_r.run && s_r.q == Q1 && !instr_i[8] && s_r.ext_en &&
      instr_i[7:0] <= ILO_LIMIT |=>
      s_r.ea == DA_W'($past(s_r.fsr) + $past(instr_i[7:0])))
    else $error("indexed operand address wrong");

  negate_flags_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_r)
    ex4 && is_neg && quiet |=>
      dmem[$past(s_r.ea)] == 8'(8'h00 - $past(s_r.opnd)) &&
      s_r.status[FL_Z] == ($past(s_r.opnd) == 8'h00) &&
      s_r.status[FL_N] == dmem[$past(s_r.ea)][7])
    else $error("negate result or flags wrong");

  pop_level_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_r)
    s_r.run && s_r.q == Q3 && !s_r.flush && is_pop &&
      s_r.sp != '0 |=> s_r.sp == $past(s_r.sp) - 1'b1)
    else $error("pop did not drop one level");

  push_head_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_r)
    s_r.run && s_r.q == Q2 && !s_r.flush && is_push &&
      s_r.sp != SP_W'(STACK_DEPTH) |=>
      head == $past(s_r.pc) + PC_STEP)
    else $error("push head not counter plus two");

  call_target_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_r)
    ex4 && is_rel_call && quiet |=> s_r.pc == $past(s_r.pc) +
      PC_STEP + {{9{$past(s_r.ir[10])}}, $past(s_r.ir[10:0]), 1'b0})
    else $error("relative call target wrong");

  call_idle_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_r)
    ex4 && is_rel_call && quiet ##1 s_r.run [*4] |->
      s_r.flush && $past(s_r.flush, 3))
    else $error("relative call idle cycle missing");

  sreset_regs_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_r)
    s_r.run && s_r.q == Q2 && !s_r.flush && is_srst && quiet |=>
      sreset_o && s_r.pc == PC_RST && s_r.sp == '0 &&
      s_r.w == W_RST ##3 s_r.pc == PC_RST)
    else $error("software reset incomplete");

  nop_quiet_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_r)
    ex4 && is_nop && quiet |=> s_r.pc == $past(s_r.pc) + PC_STEP &&
      $stable(s_r.w) && $stable(prod_o) && $stable(s_r.sp) &&
      $stable(s_r.status))
    else $error("no-operation changed state");

  mul_seen_c: cover property (
    @(posedge clk_i) disable iff (!rst_b_r) ex4 && is_mreg);
  call_seen_c: cover property (
    @(posedge clk_i) disable iff (!rst_b_r) ex4 && is_rel_call);
  push_pop_c: cover property (
    @(posedge clk_i) disable iff (!rst_b_r)
    ex4 && is_push ##[1:16] ex4 && is_pop);
  sreset_c: cover property (
    @(posedge clk_i) disable iff (!rst_b_r) sreset_o);

endmodule : core_exec

// [bench/prog_model.sv]
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// program memory seen by the core: word wide, combinational fetch
module prog_model import core_exec_pkg::*; (
  input wire logic [PC_W-1:0] pc_i,
  output logic [15:0] instr_o
);
  logic [15:0] mem [0:255];
  // unloaded words read as no-operation, so a core that runs past the
  // loaded code only walks on instead of executing junk
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 16'h0000;
    end
  end
  // words sit on even addresses, the low counter bit is not used
  assign instr_o = mem[pc_i[8:1]];
endmodule : prog_model

// [bench/tb_top.sv]
`timescale 1ns/1ps
module tb_top import core_exec_pkg::*;;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  bus_req_t bus = '0;
  logic [15:0] instr;
  logic [31:0] rd_data;
  logic [PC_W-1:0] pc;
  logic [15:0] prod;
  logic sreset;
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [7:0] nv [3] = '{8'h3a, 8'h00, 8'h80};
  logic [7:0] nr [3] = '{8'hc6, 8'h00, 8'h80};
  logic [7:0] ns [3] = '{8'h10, 8'h07, 8'h1a};

  core_exec #(.STACK_DEPTH(31), .DMEM_DEPTH(4096)) i_core_exec (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .instr_i(instr), .bus_req_i(bus),
    .rd_data_o(rd_data), .pc_o(pc), .prod_o(prod), .sreset_o(sreset));
  prog_model i_prog_model (.pc_i(pc), .instr_o(instr));

  ////////////////////////////////////////////////////////////////////////////
  // 50 ns clock; the hang guard is far above the few hundred cycles used
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_errors++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one idle edge before each strobe so a strobe is never set twice at once
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    bus <= '0;
  endtask : bus_wr

  // read data stand only in the cycle after the strobe edge
  task automatic bus_rdc(input logic [7:0] a, input logic [31:0] exp,
                         input string what);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    bus <= '0;
    #1;
    chk(what, exp, rd_data);
  endtask : bus_rdc

  // run one instruction from a halted core, wait for the counter to land
  // and then check that it holds there for the given hold count of cycles
  task automatic exec1(input logic [PC_W-1:0] start, input logic [15:0] op,
                       input logic [PC_W-1:0] dest, input logic [31:0] ctrl,
                       input int hold);
    logic hit;
    hit = 1'b0;
    i_prog_model.mem[start[8:1]] = op;
    bus_wr(R_CTRL, 32'h0);
    bus_wr(R_PC, {11'h0, start});
    bus_wr(R_CTRL, ctrl);
    for (int i = 0; i < 40 && !hit; i++) begin
      @(posedge clk_i);
      #1;
      hit = (pc === dest);
    end
    chk("pc_o target", {11'h0, dest}, {11'h0, pc});
    chk("sreset_o", {31'h0, dest == '0}, {31'h0, sreset});
    repeat (hold) begin
      @(posedge clk_i);
      #1;
      chk("pc_o hold", {11'h0, dest}, {11'h0, pc});
    end
    bus_wr(R_CTRL, 32'h0);
  endtask : exec1

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    chk("pc_o", 32'h0, {11'h0, pc});
    chk("prod_o", 32'h0, {16'h0, prod});
    bus_rdc(R_WREG, 32'h0, "w");
    bus_rdc(R_STATUS, 32'h0, "status");
    bus_rdc(R_SP, 32'h0, "depth");
    bus_rdc(8'h30, 32'h0, "unmapped");
    // literal multiply, then register forms over the banked, low and indexed paths
    bus_wr(R_WREG, 32'he2);
    exec1(21'h10, {OPC_MUL_LIT, 8'hc4}, 21'h12, 32'h1, 3);
    chk("prod_o", 32'had08, {16'h0, prod});
    bus_rdc(R_WREG, 32'he2, "w");
    bus_wr(R_STATUS, 32'h15);
    bus_wr(R_BANK, 32'h3);
    bus_wr(R_WREG, 32'hc4);
    bus_wr(R_INDEX, 32'h200);
    bus_wr(R_MPTR, 32'h012);
    bus_wr(R_MDATA, 32'h07);
    bus_wr(R_MPTR, 32'h212);
    bus_wr(R_MDATA, 32'h03);
    bus_wr(R_MPTR, 32'h25f);
    bus_wr(R_MDATA, 32'h02);
    bus_wr(R_MPTR, 32'h312);
    bus_wr(R_MDATA, 32'hb5);
    exec1(21'h20, 16'h0312, 21'h22, 32'h1, 3);
    chk("prod_o", 32'h8a94, {16'h0, prod});
    bus_rdc(R_PROD, 32'h8a94, "product");
    bus_rdc(R_MDATA, 32'hb5, "operand");
    bus_rdc(R_STATUS, 32'h15, "status");
    bus_rdc(R_WREG, 32'hc4, "w");
    exec1(21'h20, 16'h0212, 21'h22, 32'h1, 3);
    chk("prod_o", 32'h055c, {16'h0, prod});
    exec1(21'h20, 16'h0212, 21'h22, 32'h3, 3);
    chk("prod_o", 32'h024c, {16'h0, prod});
    exec1(21'h20, 16'h025f, 21'h22, 32'h3, 3);
    chk("prod_o", 32'h0188, {16'h0, prod});
    // bank bit 0 above the indexed range lands in the upper access part
    bus_wr(R_MPTR, 32'hf90);
    bus_wr(R_MDATA, 32'h05);
    exec1(21'h20, 16'h0290, 21'h22, 32'h1, 3);
    chk("prod_o", 32'h03d4, {16'h0, prod});
    // negate: ordinary, zero and the one value that overflows
    for (int k = 0; k < 3; k++) begin
      bus_wr(R_MPTR, 32'h330 + 32'(k));
      bus_wr(R_MDATA, {24'h0, nv[k]});
      exec1(21'h30, 16'h6d30 + 16'(k), 21'h32, 32'h1, 3);
      bus_rdc(R_MDATA, {24'h0, nr[k]}, "negate");
      bus_rdc(R_STATUS, {24'h0, ns[k]}, "flags");
    end
    // return stack: two pushes, a pop, then a backward relative call
    exec1(21'h40, OPC_PUSH, 21'h42, 32'h1, 3);
    bus_rdc(R_HEAD, 32'h42, "head");
    exec1(21'h42, OPC_PUSH, 21'h44, 32'h1, 3);
    bus_rdc(R_HEAD, 32'h44, "head");
    bus_rdc(R_SP, 32'h2, "depth");
    exec1(21'h44, OPC_POP, 21'h46, 32'h1, 3);
    bus_rdc(R_HEAD, 32'h42, "head");
    bus_rdc(R_SP, 32'h1, "depth");
    i_prog_model.mem[8'h21] = OPC_NOP;
    exec1(21'h46, 16'hdffd, 21'h42, 32'h1, 7);
    bus_rdc(R_HEAD, 32'h48, "head");
    bus_rdc(R_SP, 32'h2, "depth");
    // software reset clears core state, then both no-operation forms
    bus_wr(R_WREG, 32'h5a);
    exec1(21'h60, OPC_SRESET, 21'h0, 32'h1, 5);
    chk("prod_o", 32'h0, {16'h0, prod});
    bus_rdc(R_WREG, 32'h0, "w");
    bus_rdc(R_STATUS, 32'h0, "status");
    bus_rdc(R_BANK, 32'h0, "bank");
    bus_rdc(R_INDEX, 32'h0, "index");
    bus_rdc(R_SP, 32'h0, "depth");
    bus_wr(R_WREG, 32'h77);
    exec1(21'h70, 16'hf123, 21'h72, 32'h1, 3);
    exec1(21'h72, OPC_NOP, 21'h74, 32'h1, 3);
    bus_rdc(R_WREG, 32'h77, "w");
    bus_rdc(R_STATUS, 32'h0, "status");
    bus_rdc(R_SP, 32'h0, "depth");
    chk("prod_o", 32'h0, {16'h0, prod});
    final_report();
  end
endmodule : tb_top
